// ==== verilog/host_sram_port_and_irq_regs.sv ====
// Behaviour
// - Read of increment port returns data at read pointer, then steps 1/2/4 bytes.
// - Read of hold port returns data at read pointer, pointer kept.
// - Read address is two R/W bytes, low byte first, both reset to zero.
// - Setting the wrap enable bit loads read address high byte with 0Ch.
// - Write-only hold port stores data at write pointer, pointer kept.
// - Write to increment port stores data, then steps pointer 1/2/4 bytes.
// - Write address is two R/W bytes, both reset to zero.
// - Host loads frame length into two R/W bytes, low byte lower address.
// - Status bits 7:6 show bus width read-only: 00=16, 01=32, 10=8.
// - Status bits 3:0 latch four events, reset zero, write one clears.
// - Mask bits 3:0 R/W, reset zero, enable corresponding latched events onto irq.
// - With mask bit 7 set, read pointer wraps past 3FFFh to 0C00h, write pointer past 0BFFh to 0000h.
// - Reserved status bits 5:4 and mask bits 6:4 read zero, read-only.
`timescale 1ns/1ps
`default_nettype none

module host_sram_port_and_irq_regs
  import sram_port_pkg::*;
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [sram_port_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [1:0]                          bus_width_pin,
  input  wire sram_port_pkg::event_s               events,
  output logic      [15:0]                         rx_mem_addr,
  input  wire logic [31:0]                         rx_mem_rdata,
  output logic                                     tx_mem_we,
  output sram_port_pkg::mem_write_s                tx_mem_req,
  output logic      [15:0]                         tx_length,
  output logic                                     irq
);
  import sram_port_pkg::*;

  // ==========================================================
  // Bus width strap synchroniser
  // ==========================================================
  logic [1:0] width_meta_q;
  logic [1:0] bus_width_field_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_meta_q      <= BUS_16BIT;
      bus_width_field_q <= BUS_16BIT;
    end else begin
      width_meta_q      <= bus_width_pin;
      bus_width_field_q <= width_meta_q;
    end
  end

  // ==========================================================
  // Step and lane selection
  // ==========================================================
  // Reserved code 11 treated as 8-bit, the safest step
  wire logic [15:0] step;
  wire logic [31:0] lane_mask;
  wire logic [3:0]  lane_be;

  assign step      = (bus_width_field_q == BUS_32BIT) ? 16'h0004 :
                     (bus_width_field_q == BUS_16BIT) ? 16'h0002 : 16'h0001;
  assign lane_mask = (bus_width_field_q == BUS_32BIT) ? 32'hffffffff :
                     (bus_width_field_q == BUS_16BIT) ? 32'h0000ffff : 32'h000000ff;
  assign lane_be   = (bus_width_field_q == BUS_32BIT) ? 4'hf :
                     (bus_width_field_q == BUS_16BIT) ? 4'h3 : 4'h1;

  // ==========================================================
  // APB decode
  // ==========================================================
  wire logic [7:0] idx;
  wire logic       idx_ok;
  wire logic       setup_rd;
  wire logic       acc;
  wire logic       wr;
  wire logic       rd;

  assign idx      = paddr[9:2];
  assign idx_ok   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign rd       = acc && !pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  wire logic hit_rhold;
  wire logic hit_rincr;
  wire logic hit_ral;
  wire logic hit_rah;
  wire logic hit_whold;
  wire logic hit_wincr;
  wire logic hit_wal;
  wire logic hit_wah;
  wire logic hit_lenl;
  wire logic hit_lenh;
  wire logic hit_stat;
  wire logic hit_mask;
  wire logic mapped;

  assign hit_rhold = idx_ok && (idx == IDX_RX_READ_HOLD);
  assign hit_rincr = idx_ok && (idx == IDX_RX_READ_INCR);
  assign hit_ral   = idx_ok && (idx == IDX_RD_ADDR_LOW);
  assign hit_rah   = idx_ok && (idx == IDX_RD_ADDR_HIGH);
  assign hit_whold = idx_ok && (idx == IDX_TX_WRITE_HOLD);
  assign hit_wincr = idx_ok && (idx == IDX_TX_WRITE_INCR);
  assign hit_wal   = idx_ok && (idx == IDX_WR_ADDR_LOW);
  assign hit_wah   = idx_ok && (idx == IDX_WR_ADDR_HIGH);
  assign hit_lenl  = idx_ok && (idx == IDX_TX_LENGTH_LOW);
  assign hit_lenh  = idx_ok && (idx == IDX_TX_LENGTH_HIGH);
  assign hit_stat  = idx_ok && (idx == IDX_EVENT_STATUS);
  assign hit_mask  = idx_ok && (idx == IDX_EVENT_MASK);
  assign mapped    = hit_rhold || hit_rincr || hit_ral || hit_rah || hit_whold ||
                     hit_wincr || hit_wal || hit_wah || hit_lenl || hit_lenh ||
                     hit_stat || hit_mask;

  // ==========================================================
  // Bus response
  // ==========================================================
  // Every access completes in one access cycle
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [15:0] rd_ptr_q;
  logic [15:0] rd_ptr_d;
  logic [15:0] wr_ptr_q;
  logic [15:0] wr_ptr_d;
  logic [15:0] len_q;
  logic [15:0] len_d;
  logic [3:0]  flags_q;
  logic [3:0]  flags_d;
  logic [7:0]  mask_q;
  logic [7:0]  mask_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        tx_we_q;
  mem_write_s  tx_req_q;
  mem_write_s  tx_req_d;

  wire logic        wrap_en;
  wire logic [15:0] rd_sum;
  wire logic [15:0] wr_sum;
  wire logic [15:0] rd_next;
  wire logic [15:0] wr_next;
  wire logic [3:0]  ev_vec;
  wire logic [7:0]  status_rd;
  wire logic [7:0]  mask_rd;

  assign wrap_en = mask_q[POINTER_WRAP_BIT];
  assign rd_sum  = rd_ptr_q + step;
  assign wr_sum  = wr_ptr_q + step;
  // Wrap tests the stepped pointer; the store ends far below the 16-bit carry
  assign rd_next = (wrap_en && (rd_sum > MEM_LAST_ADDR)) ?
                   RX_START_ADDR : rd_sum;
  assign wr_next = (wrap_en && (wr_sum > TX_LAST_ADDR)) ?
                   TX_START_ADDR : wr_sum;
  assign ev_vec    = events;
  assign status_rd = {bus_width_field_q, 2'b00, flags_q};
  assign mask_rd   = {mask_q[7], 3'b000, mask_q[3:0]};

  // ==========================================================
  // Read pointer
  // ==========================================================
  always_comb begin
    rd_ptr_d = rd_ptr_q;
    if (rd && hit_rincr) begin
      rd_ptr_d = rd_next;
    end else if (wr && hit_ral) begin
      rd_ptr_d = {rd_ptr_q[15:8], pwdata[7:0]};
    end else if (wr && hit_rah) begin
      rd_ptr_d = {pwdata[7:0], rd_ptr_q[7:0]};
    end else if (wr && hit_mask && pwdata[POINTER_WRAP_BIT]) begin
      rd_ptr_d = {WRAP_READ_HIGH, rd_ptr_q[7:0]};
    end
  end

  // One register for both bytes keeps the step carry in one adder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_q <= {RST_BYTE, RST_BYTE};
    end else begin
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // ==========================================================
  // Write pointer
  // ==========================================================
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    if (wr && hit_wincr) begin
      wr_ptr_d = wr_next;
    end else if (wr && hit_wal) begin
      wr_ptr_d = {wr_ptr_q[15:8], pwdata[7:0]};
    end else if (wr && hit_wah) begin
      wr_ptr_d = {pwdata[7:0], wr_ptr_q[7:0]};
    end
  end

  // Same layout as the read pointer, so both step alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= {RST_BYTE, RST_BYTE};
    end else begin
      wr_ptr_q <= wr_ptr_d;
    end
  end

  // ==========================================================
  // Frame length
  // ==========================================================
  always_comb begin
    len_d = len_q;
    if (wr && hit_lenl) begin
      len_d = {len_q[15:8], pwdata[7:0]};
    end else if (wr && hit_lenh) begin
      len_d = {pwdata[7:0], len_q[7:0]};
    end
  end

  // Cleared on reset, though software must load it before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_q <= {RST_BYTE, RST_BYTE};
    end else begin
      len_q <= len_d;
    end
  end

  // ==========================================================
  // Event latches
  // ==========================================================
  always_comb begin
    flags_d = flags_q;
    if (wr && hit_stat) begin
      flags_d = flags_q & ~pwdata[3:0];
    end
    // A new event beats a clear in the same cycle
    flags_d = flags_d | ev_vec;
  end

  // Events are same-clock pulses, so no synchroniser here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // Event mask
  // ==========================================================
  always_comb begin
    mask_d = mask_q;
    if (wr && hit_mask) begin
      mask_d = {pwdata[7], 3'b000, pwdata[3:0]};
    end
  end

  // Reserved bits are never stored, so they cannot read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= RST_BYTE;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Read data captured in setup so the access sees the old pointer
  always_comb begin
    prdata_d = prdata_q;
    if (setup_rd) begin
      if (hit_rhold || hit_rincr) begin
        prdata_d = rx_mem_rdata & lane_mask;
      end else if (hit_ral) begin
        prdata_d = {24'h000000, rd_ptr_q[7:0]};
      end else if (hit_rah) begin
        prdata_d = {24'h000000, rd_ptr_q[15:8]};
      end else if (hit_wal) begin
        prdata_d = {24'h000000, wr_ptr_q[7:0]};
      end else if (hit_wah) begin
        prdata_d = {24'h000000, wr_ptr_q[15:8]};
      end else if (hit_lenl) begin
        prdata_d = {24'h000000, len_q[7:0]};
      end else if (hit_lenh) begin
        prdata_d = {24'h000000, len_q[15:8]};
      end else if (hit_stat) begin
        prdata_d = {24'h000000, status_rd};
      end else if (hit_mask) begin
        prdata_d = {24'h000000, mask_rd};
      end else begin
        prdata_d = 32'h00000000;
      end
    end
  end

  // Held between reads, so a late sample still sees the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // Transmit write request
  // ==========================================================
  wire logic tx_port_wr;
  assign tx_port_wr = wr && (hit_whold || hit_wincr);

  // Write ports store at the pointer as it was before the step
  always_comb begin
    tx_req_d = tx_req_q;
    if (wr && (hit_whold || hit_wincr)) begin
      tx_req_d.addr = wr_ptr_q;
      tx_req_d.data = pwdata & lane_mask;
      tx_req_d.be   = lane_be;
    end
  end

  // ==========================================================
  // Transmit write flip-flops
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_we_q <= 1'b0;
    end else begin
      tx_we_q <= tx_port_wr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_req_q <= '0;
    end else begin
      tx_req_q <= tx_req_d;
    end
  end

  // ==========================================================
  // Interrupt
  // ==========================================================
  // Level output, so software sees a pending event until it clears it
  wire logic [3:0] pending;
  assign pending = flags_q & mask_q[3:0];

  // ==========================================================
  // Outputs
  // ==========================================================
  assign prdata      = prdata_q;
  assign rx_mem_addr = rd_ptr_q;
  assign tx_mem_we   = tx_we_q;
  assign tx_mem_req  = tx_req_q;
  assign tx_length   = len_q;
  assign irq         = |pending;

endmodule // host_sram_port_and_irq_regs

`default_nettype wire

// ==== include/sram_port_pkg.sv ====
`default_nettype none

package sram_port_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  // ==========================================================
  localparam logic [7:0] IDX_RX_READ_HOLD    = 8'hf0;
  localparam logic [7:0] IDX_RX_READ_INCR    = 8'hf2;
  localparam logic [7:0] IDX_RD_ADDR_LOW     = 8'hf4;
  localparam logic [7:0] IDX_RD_ADDR_HIGH    = 8'hf5;
  localparam logic [7:0] IDX_TX_WRITE_HOLD   = 8'hf6;
  localparam logic [7:0] IDX_TX_WRITE_INCR   = 8'hf8;
  localparam logic [7:0] IDX_WR_ADDR_LOW     = 8'hfa;
  localparam logic [7:0] IDX_WR_ADDR_HIGH    = 8'hfb;
  localparam logic [7:0] IDX_TX_LENGTH_LOW   = 8'hfc;
  localparam logic [7:0] IDX_TX_LENGTH_HIGH  = 8'hfd;
  localparam logic [7:0] IDX_EVENT_STATUS    = 8'hfe;
  localparam logic [7:0] IDX_EVENT_MASK      = 8'hff;

  localparam int         APB_ADDR_W          = 12;

  // ==========================================================
  // Field positions and values
  // ==========================================================
  localparam int         BUS_WIDTH_LSB       = 6;
  localparam int         POINTER_WRAP_BIT    = 7;
  localparam logic [7:0] WRAP_READ_HIGH      = 8'h0c;
  localparam logic [1:0] BUS_16BIT           = 2'h0;
  localparam logic [1:0] BUS_32BIT           = 2'h1;
  localparam logic [1:0] BUS_8BIT            = 2'h2;

  // ==========================================================
  // Memory map of the packet store
  // ==========================================================
  localparam logic [15:0] RX_START_ADDR      = 16'h0c00;
  localparam logic [15:0] TX_START_ADDR      = 16'h0000;
  localparam logic [15:0] TX_LAST_ADDR       = 16'h0bff;
  localparam logic [15:0] MEM_LAST_ADDR      = 16'h3fff;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_BYTE            = 8'h00;
  localparam logic [3:0] RST_FLAGS           = 4'h0;

  typedef struct packed {
    logic rx_counter_overflow;
    logic rx_overflow;
    logic tx_done;
    logic rx_done;
  } event_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } mem_write_s;

endpackage

`default_nettype wire

// ==== bench/host_sram_port_and_irq_regs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module reg_bank_checker (
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [sram_port_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]                          pwdata,
  input wire logic [31:0]                          prdata,
  input wire logic [1:0]                           bus_width_pin,
  input wire sram_port_pkg::event_s                events,
  input wire logic [15:0]                          rx_mem_addr,
  input wire logic [31:0]                          rx_mem_rdata,
  input wire logic                                 tx_mem_we,
  input wire sram_port_pkg::mem_write_s            tx_mem_req,
  input wire logic [15:0]                          tx_length,
  input wire logic                                 irq
);
  import sram_port_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire        rd_acc = psel & penable & ~pwrite;
  wire        wr_acc = psel & penable & pwrite;
  wire [7:0]  idx    = paddr[9:2];
  wire [15:0] step   = (bus_width_pin == BUS_32BIT) ? 16'h0004 :
                       (bus_width_pin == BUS_16BIT) ? 16'h0002 : 16'h0001;
  sequence s_mask_on;
    wr_acc && idx == IDX_EVENT_MASK && pwdata[0];
  endsequence
  sequence s_clear_quiet;
    wr_acc && idx == IDX_EVENT_STATUS && pwdata[3:0] == 4'hf && events == 4'h0 ##1 events == 4'h0;
  endsequence
  // Pointer near the top is left out, the wrap case differs there
  AST_RD_INCR: assert property (rd_acc && idx == IDX_RX_READ_INCR && rx_mem_addr < 16'h3ff0 &&
    bus_width_pin == $past(bus_width_pin, 3) |=> rx_mem_addr == $past(rx_mem_addr) + $past(step))
    else $error("read pointer step wrong");
  AST_RD_HOLD: assert property (rd_acc && idx == IDX_RX_READ_HOLD |=> $stable(rx_mem_addr))
    else $error("read pointer moved on hold read");
  AST_RD_DATA: assert property (rd_acc && (idx == IDX_RX_READ_HOLD || idx == IDX_RX_READ_INCR)
    |-> prdata[7:0] == $past(rx_mem_rdata[7:0])) else $error("read port data wrong");
  AST_WR_HOLD: assert property (wr_acc && idx == IDX_TX_WRITE_HOLD
    |=> tx_mem_we && tx_mem_req.data[7:0] == $past(pwdata[7:0])) else $error("hold write lost");
  AST_WR_INCR: assert property (wr_acc && idx == IDX_TX_WRITE_INCR |=> tx_mem_we ##1 !tx_mem_we)
    else $error("increment write pulse wrong");
  AST_WRAP_HIGH: assert property (wr_acc && idx == IDX_EVENT_MASK && pwdata[7]
    |=> rx_mem_addr[15:8] == WRAP_READ_HIGH) else $error("read high byte not loaded");
  AST_LEN: assert property (wr_acc && idx == IDX_TX_LENGTH_LOW
    |=> tx_length[7:0] == $past(pwdata[7:0])) else $error("length low byte wrong");
  AST_MODE: assert property (rd_acc && idx == IDX_EVENT_STATUS && bus_width_pin == $past(bus_width_pin, 4)
    |-> prdata[7:4] == {bus_width_pin, 2'b00}) else $error("status upper bits wrong");
  AST_RSV: assert property (rd_acc && idx == IDX_EVENT_MASK |-> prdata[6:4] == 3'h0)
    else $error("mask reserved bits not zero");
  AST_IRQ_SET: assert property (s_mask_on ##1 events.rx_done |-> ##[1:2] irq)
    else $error("interrupt not raised");
  AST_IRQ_CLR: assert property (s_clear_quiet |=> !irq)
    else $error("interrupt not dropped");
  AST_RST: assert property ($rose(presetn) |-> rx_mem_addr == 16'h0000 && !irq)
    else $error("reset state wrong");
endmodule // reg_bank_checker
`default_nettype wire

// ==== bench/mem_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Packet store stand-in
module mem_far_model (
  input  wire logic                      pclk,
  input  wire logic [15:0]               rx_mem_addr,
  output logic      [31:0]               rx_mem_rdata,
  input  wire logic                      tx_mem_we,
  input  wire sram_port_pkg::mem_write_s tx_mem_req,
  output sram_port_pkg::mem_write_s      last_wr
);
  import sram_port_pkg::*;
  // Address-keyed pattern, so a wrong pointer shows as wrong data
  assign rx_mem_rdata = {~rx_mem_addr, rx_mem_addr};
  // Only the last write is kept; the bench checks each in turn, bar the 11h increment write that the next hold write overwrites
  always_ff @(posedge pclk) begin
    if (tx_mem_we) begin
      last_wr <= tx_mem_req;
    end
  end
endmodule // mem_far_model
`default_nettype wire

// ==== bench/host_sram_port_and_irq_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
// ==========
// Bench
module host_sram_port_and_irq_regs_bench;
  import sram_port_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, tx_mem_we, irq, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rx_mem_rdata, d;
  logic [1:0]  bus_width_pin = 0;
  event_s      events = 0;
  logic [15:0] rx_mem_addr, tx_length, p;
  mem_write_s  tx_mem_req, last_wr;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  logic [7:0]  rst_tbl [8] = '{IDX_RD_ADDR_LOW, IDX_RD_ADDR_HIGH, IDX_WR_ADDR_LOW, IDX_WR_ADDR_HIGH,
                               IDX_EVENT_STATUS, IDX_EVENT_MASK, IDX_TX_WRITE_HOLD, IDX_TX_WRITE_INCR};
  logic [1:0]  codes [4] = '{BUS_8BIT, 2'h3, BUS_16BIT, BUS_32BIT};
  int          steps [4] = '{1, 1, 2, 4};
  logic [3:0]  bes [4]   = '{4'h1, 4'h1, 4'h3, 4'hf};
  host_sram_port_and_irq_regs i_host_sram_port_and_irq_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_width_pin(bus_width_pin), .events(events), .rx_mem_addr(rx_mem_addr),
    .rx_mem_rdata(rx_mem_rdata), .tx_mem_we(tx_mem_we), .tx_mem_req(tx_mem_req),
    .tx_length(tx_length), .irq(irq));
  mem_far_model i_mem_far_model (.pclk(pclk), .rx_mem_addr(rx_mem_addr),
    .rx_mem_rdata(rx_mem_rdata), .tx_mem_we(tx_mem_we), .tx_mem_req(tx_mem_req), .last_wr(last_wr));
  function automatic logic [31:0] msk(input int s);
    return (s == 1) ? 32'hff : (s == 2) ? 32'hffff : 32'hffffffff;
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
    xfer(1'b1, ix, wd, d, e);
  endtask
  task automatic rc(input logic [7:0] ix, input logic [31:0] x);
    xfer(1'b0, ix, 32'h0, d, e);
    `CHK("register read", x, d)
  endtask
  task automatic txc(input logic [15:0] a, input logic [31:0] dt, input logic [3:0] be);
    repeat (2) @(posedge pclk);
    `CHK("memory write", {a, dt, be}, last_wr)
  endtask
  task automatic pulse(input logic [3:0] v);
    events <= v;
    @(posedge pclk);
    events <= 4'h0;
  endtask
  initial begin
    forever #25 pclk = ~pclk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rc(rst_tbl[i], 32'h0);
    for (int m = 0; m < 4; m++) begin
      bus_width_pin <= codes[m];
      repeat (4) @(posedge pclk);
      rc(IDX_EVENT_STATUS, {24'h0, codes[m], 6'h00});
      wr(IDX_RD_ADDR_LOW, 32'h10);
      wr(IDX_RD_ADDR_HIGH, 32'h0);
      rc(IDX_RX_READ_INCR, 32'hffef0010 & msk(steps[m]));
      p = 16'(16'h10 + steps[m]);
      rc(IDX_RX_READ_HOLD, {~p, p} & msk(steps[m]));
      rc(IDX_RD_ADDR_LOW, {16'h0, p});
      wr(IDX_WR_ADDR_LOW, 32'h20);
      wr(IDX_WR_ADDR_HIGH, 32'h0);
      wr(IDX_TX_WRITE_HOLD, 32'h5a3c96e1);
      txc(16'h20, 32'h5a3c96e1 & msk(steps[m]), bes[m]);
      wr(IDX_TX_WRITE_INCR, 32'h0f1e2d4b);
      txc(16'h20, 32'h0f1e2d4b & msk(steps[m]), bes[m]);
      wr(IDX_TX_WRITE_HOLD, 32'h5a3c96e1);
      txc(16'(16'h20 + steps[m]), 32'h5a3c96e1 & msk(steps[m]), bes[m]);
      rc(IDX_WR_ADDR_LOW, 32'(32'h20 + steps[m]));
    end
    wr(IDX_EVENT_MASK, 32'hff);
    pulse(4'hf);
    rc(IDX_EVENT_STATUS, 32'h4f);
    rc(IDX_EVENT_MASK, 32'h8f);
    rc(IDX_RD_ADDR_HIGH, 32'h0c);
    `CHK("irq", 1'b1, irq)
    wr(IDX_EVENT_STATUS, 32'hff);
    rc(IDX_EVENT_STATUS, 32'h40);
    `CHK("irq", 1'b0, irq)
    wr(IDX_EVENT_MASK, 32'h80);
    pulse(4'h2);
    rc(IDX_EVENT_STATUS, 32'h42);
    `CHK("irq", 1'b0, irq)
    wr(IDX_EVENT_STATUS, 32'h01);
    rc(IDX_EVENT_STATUS, 32'h42);
    wr(IDX_EVENT_STATUS, 32'h02);
    rc(IDX_EVENT_STATUS, 32'h40);
    wr(IDX_TX_LENGTH_LOW, 32'h34);
    wr(IDX_TX_LENGTH_HIGH, 32'h12);
    @(posedge pclk);
    `CHK("tx length", 16'h1234, tx_length)
    rc(IDX_TX_LENGTH_HIGH, 32'h12);
    bus_width_pin <= BUS_8BIT;
    repeat (4) @(posedge pclk);
    wr(IDX_RD_ADDR_LOW, 32'hff);
    wr(IDX_RD_ADDR_HIGH, 32'h3f);
    rc(IDX_RX_READ_INCR, 32'hff);
    rc(IDX_RD_ADDR_LOW, 32'h0);
    rc(IDX_RD_ADDR_HIGH, 32'h0c);
    wr(IDX_WR_ADDR_LOW, 32'hff);
    wr(IDX_WR_ADDR_HIGH, 32'h0b);
    wr(IDX_TX_WRITE_INCR, 32'h11);
    wr(IDX_TX_WRITE_HOLD, 32'h22);
    txc(16'h0, 32'h22, 4'h1);
    xfer(1'b0, 8'hef, 32'h0, d, e);
    `CHK("slave error", 1'b1, e)
    `CHK("unmapped read", 32'h0, d)
    wrap_up();
  end
endmodule // host_sram_port_and_irq_regs_bench
bind host_sram_port_and_irq_regs reg_bank_checker i_reg_bank_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .bus_width_pin(bus_width_pin),
  .events(events), .rx_mem_addr(rx_mem_addr), .rx_mem_rdata(rx_mem_rdata),
  .tx_mem_we(tx_mem_we), .tx_mem_req(tx_mem_req), .tx_length(tx_length), .irq(irq));
`default_nettype wire
